// *** src/sar_adc_sequencer.sv ***
// successive approximation converter sequencer, top level
`timescale 1ns/100ps

// Notes on behaviour
// - ten-bit result by successive approximation
// - one of eleven sources onto hold
// - positive reference: pin or supply
// - clock select codes: dividers or rc
// - conversion lasts 11.5 bit periods
// - next cycle: load, clear busy, flag, reconnect
// - hold disconnected before first decision
// - divided clock tracks system clock
// - flag set after every completed conversion
// - flag stays until software clears
// - request when flag and enable set
// - request during sleep wakes core
// - vector only with both global enables
// - sleep operation only with rc clock
// - format bit picks justification
// - powered while on; no same-write start
// - early clear stores filled partial result
// - rc delays start; else sleep aborts
module sar_adc_sequencer (
  input  wire logic                    clk_in,
  input  wire logic                    rst_b_in,
  input  wire logic                    converter_on_in,
  input  wire logic                    start_in,
  input  wire logic                    abort_in,
  input  wire sar_adc_pkg::conv_cfg_t  cfg_in,
  input  wire logic                    flag_clear_in,
  input  wire logic                    conversion_irq_enable_in,
  input  wire logic                    global_irq_enable_in,
  input  wire logic                    peripheral_irq_enable_in,
  input  wire logic                    sleep_in,
  input  wire logic                    rc_osc_in,
  input  wire logic                    comparator_in,
  output logic [9:0]                   sar_trial_out,
  output logic [10:0]                  channel_connect_out,
  output logic                         hold_connect_out,
  output logic                         reference_external_out,
  output logic                         converter_power_out,
  output logic                         busy_out,
  output sar_adc_pkg::result_pair_t    result_out,
  output logic                         conversion_done_flag_out,
  output logic                         irq_request_out,
  output logic                         wake_out,
  output logic                         irq_vector_out
);

  // all state of the sequencer
  typedef struct packed {
    sar_adc_pkg::seq_state_t   state;      // sequencer state
    logic [2:0]                cmp_sync;   // comparator synchroniser
    logic                      cmp_val;    // filtered comparator
    logic                      prev_on;    // converter on, last cycle
    logic                      sleep_off;  // powered down by sleep
    logic [2:0]                delay_cnt;  // rc start delay counter
    logic [4:0]                hcnt;       // half periods since start
    logic [9:0]                sar;        // trial and resolved bits
    logic [9:0]                mask;       // resolved bit marks
    logic [3:0]                bit_idx;    // bit under trial
    logic                      busy;       // conversion in progress
    logic                      hold_conn;  // hold cap on input
    logic [10:0]               chan;       // one-hot source select
    logic                      ref_ext;    // external reference
    logic                      power;      // analog power
    sar_adc_pkg::result_pair_t result;     // result pair
    logic                      flag;       // completion flag
    logic                      irq;        // interrupt request
    logic                      wake;       // wake request
    logic                      vector;     // vector request
  } seq_regs_t;

  // one state struct and its next-state copy
  seq_regs_t   s_reg;       // registered state
  seq_regs_t   s_next;      // next state
  logic        half_tick;   // half bit-period pulse
  logic        rc_sel;      // rc oscillator selected
  logic        tick_run;    // divider runs during conversion
  logic [10:0] chan_decode; // per-source code match

  // codes x11 pick the rc oscillator whatever bit two holds
  assign rc_sel   = (cfg_in.conversion_clock_select[1:0] == sar_adc_pkg::CLK_RC_LOW);
  // divider runs only in convert, so each conversion starts on a whole period
  assign tick_run = (s_reg.state == sar_adc_pkg::ST_CONVERT);

  for (genvar g = 0; g < 11; g++) begin : g_chan
    // source g connects only on an exact code match
    assign chan_decode[g] = (cfg_in.channel_select == 5'(g));
  end

  // the generator restarts whenever the sequencer leaves convert,
  // so a stale divider count never shortens the first period
  // bit period clock source
  tad_tick_gen u_tick (
    .clk_in          (clk_in),
    .rst_b_in        (rst_b_in),
    .run_in          (tick_run),
    .clock_select_in (cfg_in.conversion_clock_select),
    .rc_osc_in       (rc_osc_in),
    .half_tick_out   (half_tick)
  );

  // fill unresolved bits with the last resolved one
  // with nothing resolved yet the partial result is all zero
  function automatic logic [9:0] fill_partial(input logic [9:0] sar,
                                              input logic [9:0] mask);
    logic [9:0] res;
    logic       last;
    res  = 10'h000;
    last = 1'b0;
    for (int i = 9; i >= 0; i--) begin
      if (mask[i]) begin
        last = sar[i];
      end
      res[i] = last;
    end
    return res;
  endfunction : fill_partial

  // place the result in the byte pair
  // byte placement per format
  function automatic sar_adc_pkg::result_pair_t place(input logic [9:0] r,
                                                      input logic       left);
    sar_adc_pkg::result_pair_t p;
    if (left) begin
      p.result_high_byte = r[9:2];
      p.result_low_byte  = {r[1:0], sar_adc_pkg::RESULT_PAD};
    end else begin
      p.result_high_byte = {sar_adc_pkg::RESULT_PAD, r[9:8]};
      p.result_low_byte  = r[7:0];
    end
    return p;
  endfunction : place

  // next state of the whole sequencer
  // one process decides every register, so no two branches race
  always_comb begin
    // half tick count if this cycle carries a tick
    logic [4:0] hnext;
    logic       set_flag;
    hnext    = s_reg.hcnt + 5'h01;
    set_flag = 1'b0;
    // defaults: every register holds unless a branch says otherwise
    s_next   = s_reg;
    // the comparator settles in analog time, so it is treated as
    // asynchronous and a decision reads only the filtered value
    // comparator: change counts once stages two and three agree
    s_next.cmp_sync = {s_reg.cmp_sync[1:0], comparator_in};
    if (s_reg.cmp_sync[1] == s_reg.cmp_sync[2]) begin
      s_next.cmp_val = s_reg.cmp_sync[2];
    end
    s_next.prev_on = converter_on_in;
    s_next.chan = chan_decode;
    s_next.ref_ext = cfg_in.positive_reference_select;
    // a divided clock stops with the core in sleep, so the analog
    // side stays powered down until the core is awake again
    // sleep off without rc
    if (!sleep_in) begin
      s_next.sleep_off = 1'b0;
    end else if (!rc_sel && converter_on_in) begin
      s_next.sleep_off = 1'b1;
    end
    case (s_reg.state)
      // waiting for a start
      sar_adc_pkg::ST_IDLE: begin
        // analog side needs a cycle of power before sampling
        // start needs on beforehand
        if (start_in && s_reg.prev_on && converter_on_in && !s_next.sleep_off) begin
          // go bit reads back as busy
          s_next.busy      = 1'b1;
          s_next.hold_conn = 1'b0;
          s_next.sar       = sar_adc_pkg::SAR_START_CODE;
          s_next.mask      = 10'h000;
          s_next.bit_idx   = sar_adc_pkg::MSB_INDEX;
          s_next.hcnt      = 5'h00;
          s_next.delay_cnt = 3'h0;
          s_next.state = rc_sel ? sar_adc_pkg::ST_DELAY : sar_adc_pkg::ST_CONVERT;
        end
      end
      // the extra instruction cycle lets the core reach sleep
      // before the first bit period, keeping switching noise low
      // rc start delay
      sar_adc_pkg::ST_DELAY: begin
        s_next.delay_cnt = s_reg.delay_cnt + 3'h1;
        if (s_next.delay_cnt == sar_adc_pkg::INSTR_CYCLE_CLKS) begin
          s_next.state = sar_adc_pkg::ST_CONVERT;
        end
      end
      // bit decisions on half ticks
      sar_adc_pkg::ST_CONVERT: begin
        if (half_tick) begin
          s_next.hcnt = hnext;
          // odd half ticks from the fifth on close a bit period
          // msb first from second period
          if (hnext[0] && hnext >= sar_adc_pkg::FIRST_DECISION_HALF) begin
            // keep or drop the trial bit
            s_next.sar[s_reg.bit_idx]  = s_reg.cmp_val;
            s_next.mask[s_reg.bit_idx] = 1'b1;
            // trial the next bit down; the lsb raises none
            if (s_reg.bit_idx != 4'h0) begin
              s_next.sar[s_reg.bit_idx - 4'h1] = 1'b1;
              s_next.bit_idx = s_reg.bit_idx - 4'h1;
            end
          end
          if (hnext == sar_adc_pkg::HALF_TICKS_PER_CONV) begin
            s_next.state = sar_adc_pkg::ST_FINISH;
          end
        end
      end
      // completion cycle
      sar_adc_pkg::ST_FINISH: begin
        // load, clear, flag, reconnect
        // format is sampled here, so a late format change still
        // applies to the result being stored
        // justification by format bit
        s_next.result    = place(s_reg.sar, cfg_in.result_format_select);
        s_next.busy      = 1'b0;
        s_next.hold_conn = 1'b1;
        s_next.state     = sar_adc_pkg::ST_IDLE;
        set_flag = 1'b1;
        // an rc conversion that cannot wake the core powers down
        // rc in sleep, no irq: off
        if (sleep_in && !conversion_irq_enable_in) begin
          s_next.sleep_off = 1'b1;
        end
      end
      // all four encodings are states; an unknown value falls back to idle
      default: begin
        s_next.state = sar_adc_pkg::ST_IDLE;
      end
    endcase
    // a software abort keeps the resolved bits; sleep or power
    // loss keeps nothing, since the trial code means nothing then
    // and the old result stays readable
    // aborts during delay or conversion
    if (s_reg.state == sar_adc_pkg::ST_DELAY || s_reg.state == sar_adc_pkg::ST_CONVERT) begin
      if (abort_in) begin
        s_next.result = place(fill_partial(s_reg.sar, s_reg.mask),
                              cfg_in.result_format_select);
        s_next.busy      = 1'b0;
        s_next.hold_conn = 1'b1;
        s_next.state     = sar_adc_pkg::ST_IDLE;
      end else if (s_next.sleep_off || !converter_on_in) begin
        s_next.busy      = 1'b0;
        s_next.hold_conn = 1'b1;
        s_next.state     = sar_adc_pkg::ST_IDLE;
      end
    end
    // analog power drops in the cycle a sleep abort is taken
    // power only while on
    s_next.power = converter_on_in && !s_next.sleep_off;
    // hardware never clears the flag; a clear that meets a new
    // completion loses, so no result goes unflagged
    // set wins over software clear
    s_next.flag = set_flag || (s_reg.flag && !flag_clear_in);
    // request tracks the flag, so clearing the flag drops it
    // flag and enable
    s_next.irq = s_next.flag && conversion_irq_enable_in;
    s_next.wake = s_next.irq && sleep_in;
    // in sleep the core resumes in line first, so no vector yet
    // vector needs both enables
    s_next.vector = s_next.irq && !sleep_in && global_irq_enable_in
                    && peripheral_irq_enable_in;
  end

  // only the hold switch leaves reset closed; everything else
  // starts cleared, with the converter idle and unpowered
  // state register, synchronous reset
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s_reg           <= '0;
      s_reg.hold_conn <= sar_adc_pkg::HOLD_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // no output has logic after its flop, so the analog side
  // sees glitch-free switch, reference and power controls
  // and software reads settled status
  // outputs straight from the state flops
  assign sar_trial_out            = s_reg.sar;
  assign channel_connect_out      = s_reg.chan;
  assign hold_connect_out         = s_reg.hold_conn;
  assign reference_external_out   = s_reg.ref_ext;
  assign converter_power_out      = s_reg.power;
  assign busy_out                 = s_reg.busy;
  assign result_out               = s_reg.result;
  assign conversion_done_flag_out = s_reg.flag;
  assign irq_request_out          = s_reg.irq;
  assign wake_out                 = s_reg.wake;
  assign irq_vector_out           = s_reg.vector;

endmodule : sar_adc_sequencer

// *** src/sar_adc_pkg.sv ***
// shared constants and types of the converter sequencer
package sar_adc_pkg;

  // result and channel geometry
  localparam int unsigned RESULT_BITS  = 10;
  localparam int unsigned NUM_CHANNELS = 11;
  localparam int unsigned CHAN_SEL_W   = 5;
  localparam int unsigned CLK_SEL_W    = 3;
  localparam int unsigned HALF_DIV_W   = 5;

  // system clock period of this build
  localparam int unsigned SYS_CLK_PERIOD_NS = 10;

  // conversion length in half bit periods (11.5 periods)
  localparam logic [4:0] HALF_TICKS_PER_CONV = 5'h17;
  // first decision ends the second full period
  localparam logic [4:0] FIRST_DECISION_HALF = 5'h05;
  // extra instruction cycle in system clocks (rc source)
  localparam logic [2:0] INSTR_CYCLE_CLKS    = 3'h4;

  // trial code loaded at start: msb set
  localparam logic [9:0] SAR_START_CODE = 10'h200;
  localparam logic [3:0] MSB_INDEX      = 4'h9;

  // conversion clock select codes
  localparam logic [2:0] CLK_DIV2   = 3'h0;
  localparam logic [2:0] CLK_DIV4   = 3'h4;
  localparam logic [2:0] CLK_DIV8   = 3'h1;
  localparam logic [2:0] CLK_DIV16  = 3'h5;
  localparam logic [2:0] CLK_DIV32  = 3'h2;
  localparam logic [2:0] CLK_DIV64  = 3'h6;
  localparam logic [1:0] CLK_RC_LOW = 2'h3;

  // result byte fill
  localparam logic [5:0] RESULT_PAD = 6'h00;

  // sequencer states, gray along idle-delay-convert-finish
  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_DELAY   = 2'h1,
    ST_CONVERT = 2'h3,
    ST_FINISH  = 2'h2
  } seq_state_t;

  // software configuration carried as one group
  typedef struct packed {
    logic [CHAN_SEL_W-1:0] channel_select;
    logic                  positive_reference_select;
    logic [CLK_SEL_W-1:0]  conversion_clock_select;
    logic                  result_format_select;
  } conv_cfg_t;

  // result register pair
  typedef struct packed {
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
  } result_pair_t;

  // reset values
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic       HOLD_RESET   = 1'b1;

endpackage : sar_adc_pkg

// *** src/tad_tick_gen.sv ***
// half bit-period tick generator: system clock divider or rc oscillator
`timescale 1ns/100ps

module tad_tick_gen (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       run_in,
  input  wire logic [2:0] clock_select_in,
  input  wire logic       rc_osc_in,
  output logic            half_tick_out
);

  // all state of the generator
  typedef struct packed {
    logic [2:0] rc_sync;  // three stage synchroniser
    logic       rc_level; // filtered oscillator level
    logic [4:0] div_cnt;  // system clock divider
    logic       tick;     // half period pulse
  } tick_state_t;

  tick_state_t s_reg;   // registered state
  tick_state_t s_next;  // next state
  logic [4:0]  half_div; // half period in system clocks, minus one

  // half divider from the select code
  always_comb begin
    case (clock_select_in)
      sar_adc_pkg::CLK_DIV2:  half_div = 5'h00;
      sar_adc_pkg::CLK_DIV4:  half_div = 5'h01;
      sar_adc_pkg::CLK_DIV8:  half_div = 5'h03;
      sar_adc_pkg::CLK_DIV16: half_div = 5'h07;
      sar_adc_pkg::CLK_DIV32: half_div = 5'h0f;
      sar_adc_pkg::CLK_DIV64: half_div = 5'h1f;
      default:                half_div = 5'h00;
    endcase
  end

  // next state
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    // oscillator passes three flops
    s_next.rc_sync = {s_reg.rc_sync[1:0], rc_osc_in};
    if (s_reg.rc_sync[1] == s_reg.rc_sync[2]) begin
      s_next.rc_level = s_reg.rc_sync[2];
    end
    if (!run_in) begin
      // restart so the first tick lands one half period after start
      s_next.div_cnt = 5'h00;
    end else if (clock_select_in[1:0] == sar_adc_pkg::CLK_RC_LOW) begin
      // each rc edge is one half period, independent of system clock
      s_next.tick = (s_next.rc_level != s_reg.rc_level);
    end else if (s_reg.div_cnt >= half_div) begin
      s_next.div_cnt = 5'h00;
      s_next.tick    = 1'b1;
    end else begin
      s_next.div_cnt = s_reg.div_cnt + 5'h01;
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign half_tick_out = s_reg.tick;

endmodule : tad_tick_gen

// *** sim/sar_adc_sequencer_properties.sv ***
// port-level assertions for the converter sequencer
`timescale 1ns/100ps
module sar_adc_sequencer_properties (
  input wire logic                   clk_in,
  input wire logic                   rst_b_in,
  input wire logic                   converter_on_in,
  input wire logic                   start_in,
  input wire logic                   abort_in,
  input wire sar_adc_pkg::conv_cfg_t cfg_in,
  input wire logic                   flag_clear_in,
  input wire logic                   conversion_irq_enable_in,
  input wire logic                   global_irq_enable_in,
  input wire logic                   sleep_in,
  input wire logic [10:0]            channel_connect_out,
  input wire logic                   hold_connect_out,
  input wire logic                   reference_external_out,
  input wire logic                   busy_out,
  input wire logic                   conversion_done_flag_out,
  input wire logic                   irq_request_out,
  input wire logic                   wake_out,
  input wire logic                   irq_vector_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic rc_sel;  // rc oscillator chosen
  assign rc_sel = (cfg_in.conversion_clock_select[1:0] == 2'h3);
  a_start_busy: assert property (!busy_out && start_in && converter_on_in && !rc_sel
    && $past(converter_on_in) && $past(rst_b_in) && !sleep_in && !$past(sleep_in)
    |=> busy_out && !hold_connect_out) else $error("start not taken");
  a_hold_open: assert property (busy_out |-> !hold_connect_out)
    else $error("hold connected while busy");
  a_flag_sticky: assert property (conversion_done_flag_out && !flag_clear_in
    |=> conversion_done_flag_out) else $error("flag dropped alone");
  a_flag_clear: assert property (flag_clear_in && !busy_out |=> !conversion_done_flag_out)
    else $error("flag not cleared");
  a_done_flag: assert property ($fell(busy_out) && !$past(abort_in) && !$past(sleep_in)
    && !sleep_in && $past(converter_on_in) |-> conversion_done_flag_out)
    else $error("no flag at completion");
  a_irq_follow: assert property (irq_request_out == (conversion_done_flag_out
    && $past(conversion_irq_enable_in))) else $error("irq wrong");
  a_wake_sleep: assert property (irq_request_out && $past(sleep_in) |-> wake_out)
    else $error("no wake");
  a_vector_gate: assert property (!global_irq_enable_in && !$past(global_irq_enable_in)
    |-> !irq_vector_out) else $error("vector without global enable");
  a_chan_select: assert property ($past(rst_b_in) && $stable(cfg_in.channel_select)
    |-> channel_connect_out == (cfg_in.channel_select < 11 ? 11'h1 << cfg_in.channel_select
    : 11'h0)) else $error("channel connect wrong");
  a_ref_follow: assert property ($past(rst_b_in) |-> reference_external_out
    == $past(cfg_in.positive_reference_select)) else $error("reference wrong");
  c_start: cover property (!busy_out ##1 busy_out);
  c_abort: cover property (busy_out && abort_in);
  c_wake: cover property (wake_out);
endmodule : sar_adc_sequencer_properties

bind sar_adc_sequencer sar_adc_sequencer_properties chk_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .converter_on_in(converter_on_in), .start_in(start_in), .abort_in(abort_in), .cfg_in(cfg_in),
  .flag_clear_in(flag_clear_in), .conversion_irq_enable_in(conversion_irq_enable_in),
  .global_irq_enable_in(global_irq_enable_in), .sleep_in(sleep_in),
  .channel_connect_out(channel_connect_out), .hold_connect_out(hold_connect_out),
  .reference_external_out(reference_external_out), .busy_out(busy_out),
  .conversion_done_flag_out(conversion_done_flag_out), .irq_request_out(irq_request_out),
  .wake_out(wake_out), .irq_vector_out(irq_vector_out));

// *** sim/sar_adc_sequencer_tb.sv ***
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
module sar_adc_sequencer_tb;
  logic clk_in = 1'b0, rst_b_in = 1'b0, on = 1'b0, go = 1'b0, stop = 1'b0, clr = 1'b0;
  logic ie = 1'b0, ge = 1'b0, pe = 1'b0, sleep = 1'b0, rc = 1'b0, cmp = 1'b0;
  sar_adc_pkg::conv_cfg_t    cfg = '0;  // software configuration
  sar_adc_pkg::result_pair_t res;       // result pair
  logic [9:0]  sar, ana = 10'h000;      // trial code, analog level
  logic [10:0] chan;
  logic        hold, ref_ext, pwr, busy, flag, irq, wake, vec;
  int          miscompares = 0, samples_checked = 0, cyc = 0, n, h;
  logic [2:0]  codes [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};  // /2 up to /64
  sar_adc_sequencer dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .converter_on_in(on),
    .start_in(go), .abort_in(stop), .cfg_in(cfg), .flag_clear_in(clr),
    .conversion_irq_enable_in(ie), .global_irq_enable_in(ge), .peripheral_irq_enable_in(pe),
    .sleep_in(sleep), .rc_osc_in(rc), .comparator_in(cmp), .sar_trial_out(sar),
    .channel_connect_out(chan), .hold_connect_out(hold), .reference_external_out(ref_ext),
    .converter_power_out(pwr), .busy_out(busy), .result_out(res),
    .conversion_done_flag_out(flag), .irq_request_out(irq), .wake_out(wake),
    .irq_vector_out(vec));
  always #5 clk_in = ~clk_in;
  // free-running rc oscillator, phase unrelated to clk_in
  always #37 rc = ~rc;
  // comparator: analog level at or above trial code
  always @(negedge clk_in) cmp <= (ana >= sar);
  // hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      results();
    end
  end
  // expected result pair placement
  function automatic logic [15:0] fmt(input logic [9:0] r, input logic left);
    return left ? {r, 6'h00} : {6'h00, r};
  endfunction : fmt
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : check
  // one conversion; cut gives the cycle of an abort or sleep entry
  task automatic conv(input logic [2:0] code, input int cut, input logic slp);
    @(negedge clk_in);
    cfg.conversion_clock_select = code;
    ana = 10'($urandom);
    go = 1'b1;
    @(negedge clk_in);
    go = 1'b0;
    n = 1;
    check(16'(busy), 16'h1, "busy");
    while (busy !== 1'b0 && n < 4000) begin
      if (n == cut) begin
        if (slp) sleep = 1'b1;
        else stop = 1'b1;
      end
      @(negedge clk_in);
      stop = 1'b0;
      n++;
    end
    check(16'(busy), 16'h0, "busy end");
  endtask : conv
  // software flag clear
  task automatic clear();
    clr = 1'b1;
    @(negedge clk_in);
    clr = 1'b0;
    @(negedge clk_in);
    check(16'(flag), 16'h0, "flag clear");
  endtask : clear
  task automatic results();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  initial begin
    n = $urandom(41932);
    repeat (20) @(negedge clk_in);
    rst_b_in = 1'b1;
    // start in the same write as power-on is ignored
    on = 1'b1;
    go = 1'b1;
    @(negedge clk_in);
    go = 1'b0;
    repeat (3) @(negedge clk_in);
    check(16'({busy, pwr}), 16'h1, "same-write start");
    $display("test refuse done");
    // every divider code, conversion length and finish
    for (int i = 0; i < 6; i++) begin
      h = 1 << i;
      cfg.result_format_select = 1'($urandom);
      conv(codes[i], 0, 1'b0);
      check(16'(n >= 23 * h + 1 && n <= 23 * h + 5), 16'h1, "length");
      if (h > 2) check(res, fmt(ana, cfg.result_format_select), "result");
      check(16'({flag, hold, busy}), 16'h6, "finish");
      repeat (5) @(negedge clk_in);
      check(16'(flag), 16'h1, "flag held");
      clear();
    end
    $display("test dividers done");
    // random channel, reference, format and enables
    for (int i = 0; i < 6; i++) begin
      cfg.channel_select = 5'($urandom_range(15));
      cfg.positive_reference_select = 1'($urandom);
      cfg.result_format_select = 1'($urandom);
      {ie, ge, pe} = 3'($urandom);
      repeat (4) @(negedge clk_in);
      conv(i[0] ? 3'h5 : 3'h1, 0, 1'b0);
      check(res, fmt(ana, cfg.result_format_select), "result");
      check(16'(chan), 16'(cfg.channel_select < 11 ? 11'h1 << cfg.channel_select : 11'h0),
        "channel");
      check(16'(ref_ext), 16'(cfg.positive_reference_select), "reference");
      repeat (2) @(negedge clk_in);
      check(16'({irq, vec}), 16'({ie, ie & ge & pe}), "irq");
      clear();
    end
    $display("test random done");
    // early abort after two resolved bits
    cfg.result_format_select = 1'b0;
    conv(3'h6, 260, 1'b0);
    repeat (2) @(negedge clk_in);
    check(res, fmt({ana[9:8], {8{ana[8]}}}, 1'b0), "partial");
    check(16'(flag), 16'h0, "abort flag");
    // sleep with divided clock aborts and powers down
    conv(3'h6, 100, 1'b1);
    repeat (2) @(negedge clk_in);
    check(16'({flag, pwr}), 16'h0, "sleep abort");
    sleep = 1'b0;
    $display("test abort done");
    // rc clock keeps converting in sleep and wakes the core
    {ie, ge} = 2'h2;
    conv(3'h3, 2, 1'b1);
    repeat (2) @(negedge clk_in);
    check(res, fmt(ana, cfg.result_format_select), "rc result");
    check(16'({irq, wake, vec}), 16'h6, "wake");
    sleep = 1'b0;
    clear();
    $display("test rc done");
    // converter off drops analog power
    on = 1'b0;
    repeat (2) @(negedge clk_in);
    check(16'({pwr, busy}), 16'h0, "power off");
    on = 1'b1;
    $display("test power done");
    results();
  end
endmodule : sar_adc_sequencer_tb
